//--- pwm_pkg.sv
// shared register map, field positions and reset values of the pwm block
package pwm_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] PHASE_OFS = 8'h08;
  localparam logic [7:0] DEAD_OFS = 8'h0c;
  localparam logic [7:0] TRIG_OFS = 8'h10;
  localparam logic [7:0] TRGCON_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] INTST_OFS = 8'h1c;
  localparam logic [7:0] INTMASK_OFS = 8'h20;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SWAP_BIT = 1;
  localparam int CTRL_IMM_PHASE_BIT = 2;
  localparam int CTRL_IMM_PERIOD_BIT = 3;
  localparam int CTRL_MODE_LSB = 10;
  // trigger control fields
  localparam int TRG_DIV_LSB = 12;
  localparam int TRG_STRT_LSB = 0;
  // status register fields
  localparam int STAT_SEL_BIT = 16;
  localparam int STAT_UP_BIT = 17;
  // interrupt status bits
  localparam int INT_TRIG_BIT = 0;
  localparam int INT_CYCLE_BIT = 1;
  // reset values
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [7:0] DEAD_RST = 8'h04;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // output mode field encoding
  typedef enum logic [1:0] {
    MODE_COMPL = 2'h0,
    MODE_REDUND = 2'h1,
    MODE_PUSHPULL = 2'h2,
    MODE_OFF = 2'h3
  } out_mode_type;
endpackage

//--- dead_time_gen.sv
// dead time insertion between the high and low side pins
`timescale 1ns/1ns
module dead_time_gen #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // requests after routing
  input wire logic reqHigh,
  input wire logic reqLow,
  input wire logic enforce,
  input wire logic [DW-1:0] deadCount,
  // pins
  output logic pinHigh,
  output logic pinLow
);
  typedef struct packed {
    logic hi;
    logic lo;
    logic [DW-1:0] gap;
  } dt_type;
  dt_type st;
  dt_type next_st;
  logic gapOk;

  if (DW < 1 || DW > 16)
  begin : g_chk
    $error("dead time width out of range");
  end

  // with enforce set, an output turns on only after both were off for the dead time
  always_comb
  begin
    next_st = st;
    gapOk = st.gap >= deadCount;
    if (!enforce)
    begin
      next_st.hi = reqHigh;
      next_st.lo = reqLow;
    end
    else
    begin
      next_st.hi = reqHigh && (st.hi || (!st.lo && !reqLow && gapOk));
      next_st.lo = reqLow && (st.lo || (!st.hi && !reqHigh && gapOk));
    end
    if (st.hi || st.lo)
    begin
      next_st.gap = '0;
    end
    else if (!(&st.gap))
    begin
      next_st.gap = st.gap + 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pinHigh = st.hi;
  assign pinLow = st.lo;

  chk_dead_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($past(enforce) && $rose(st.hi)) |-> ($past(st.gap) >= $past(deadCount)) && !$past(st.lo))
    else $error("high side turned on inside dead time");
  chk_dead_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($past(enforce) && $rose(st.lo)) |-> ($past(st.gap) >= $past(deadCount)) && !$past(st.hi))
    else $error("low side turned on inside dead time");
endmodule

//--- pwm_update_and_trigger_logic.sv
// center-aligned pwm channel with update, push-pull and trigger logic
// Summary of operation
// - in complementary mode dead time is always kept, even when swap changes while running.
// - the swap bit exchanges the high and low pin routing; clearing it restores it.
// - with immediate update off, a phase write while enabled is held until the cycle midpoint.
// - with immediate update on, a phase write takes effect at once.
// - output mode 10 selects push-pull, alternating pulses between the two pins.
// - immediate period update applies a period write at once; a lower period written while counting down can start a second pulse.
// - the trigger fires when the counter meets the compare value while counting up or at zero, first time included.
// - a four-bit divider field thins out trigger outputs.
// - a six-bit start select field delays triggers; zero gives a timely first one.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module pwm_update_and_trigger_logic #(
  parameter int CW = 16,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins and events
  output logic highSideOutput,
  output logic lowSideOutput,
  output logic primaryTrigger,
  output logic irq
);
  import pwm_pkg::*;

  typedef struct packed {
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic awRdy;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wRdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arRdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable, swap, immPhase, immPeriod;
    out_mode_type mode;
    logic [CW-1:0] periodBuf, periodAct, phaseBuf, phaseAct, count, trigCmp;
    logic phasePend;
    logic [7:0] dead;
    logic [3:0] trigger_output_divider, divCnt;
    logic [5:0] postscaler_start_select, strtCnt;
    logic up, ppSel, trig, irq, reqH, reqL, enforce;
    logic [1:0] intSt, intMask;
  } state_type;

  state_type st;
  state_type next_st;
  logic doWrite;
  logic [32:0] curWord;
  logic [32:0] rdWord;
  logic [31:0] wrVal;
  logic phaseWr;
  logic periodWr;
  logic mid;
  logic start;
  logic on;
  logic match;
  logic allowed;
  logic fire;
  logic onH;
  logic onL;

  if (CW < 2 || CW > 16 || ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk
    $error("counter or address width out of range");
  end

  // read value of a register, msb flags a mapped address
  function automatic logic [32:0] regRead(input logic [ADDR_W-1:0] a, input state_type s);
    logic [31:0] r;
    logic ok;
    r = '0;
    ok = 1'b1;
    unique case (a[7:0] & 8'hfc)
      CTRL_OFS:
      begin
        r[CTRL_EN_BIT] = s.enable;
        r[CTRL_SWAP_BIT] = s.swap;
        r[CTRL_IMM_PHASE_BIT] = s.immPhase;
        r[CTRL_IMM_PERIOD_BIT] = s.immPeriod;
        r[CTRL_MODE_LSB+:2] = s.mode;
      end
      PERIOD_OFS: r[CW-1:0] = s.periodBuf;
      PHASE_OFS: r[CW-1:0] = s.phaseBuf;
      DEAD_OFS: r[7:0] = s.dead;
      TRIG_OFS: r[CW-1:0] = s.trigCmp;
      TRGCON_OFS:
      begin
        r[TRG_DIV_LSB+:4] = s.trigger_output_divider;
        r[TRG_STRT_LSB+:6] = s.postscaler_start_select;
      end
      STAT_OFS:
      begin
        r[CW-1:0] = s.count;
        r[STAT_SEL_BIT] = s.ppSel;
        r[STAT_UP_BIT] = s.up;
      end
      INTST_OFS: r[1:0] = s.intSt;
      INTMASK_OFS: r[1:0] = s.intMask;
      default: ok = 1'b0;
    endcase
    // only the low 256 bytes are mapped; wider buses refuse the rest
    if ((32'(a) >> 8) != 32'h0)
    begin
      ok = 1'b0;
      r = '0;
    end
    return {ok, r};
  endfunction

  // byte-lane merge so a narrow write keeps the untouched lanes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  // bus slave, counter, update, output and trigger logic
  always_comb
  begin
    next_st = st;
    curWord = regRead(st.awAddr, st);
    rdWord = regRead(araddr, st);
    doWrite = st.awHeld && st.wHeld && !st.bvalid;
    wrVal = merge(curWord[31:0], st.wData, st.wStrb);
    phaseWr = doWrite && (st.awAddr[7:0] & 8'hfc) == PHASE_OFS;
    periodWr = doWrite && (st.awAddr[7:0] & 8'hfc) == PERIOD_OFS;
    mid = st.enable && st.up && st.count >= st.periodAct;
    start = st.enable && !st.up && st.count == '0;
    on = st.enable && ({1'b0, st.count} + {1'b0, st.phaseAct} > {1'b0, st.periodAct});
    match = st.enable && st.count == st.trigCmp && (st.up || st.count == '0);
    allowed = st.strtCnt >= st.postscaler_start_select;
    fire = match && allowed && st.divCnt == '0;
    // write address and data captured in either order
    if (awvalid && st.awRdy)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wRdy)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (doWrite)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = curWord[32] ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.awRdy = !next_st.awHeld && !next_st.bvalid;
    next_st.wRdy = !next_st.wHeld && !next_st.bvalid;
    // read answer one cycle after the address is taken
    if (st.rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && st.arRdy)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rdWord[31:0];
      next_st.rresp = rdWord[32] ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.arRdy = !next_st.rvalid;
    // up/down counter of the center-aligned cycle
    if (!st.enable)
    begin
      next_st.count = '0;
      next_st.up = 1'b1;
      next_st.ppSel = 1'b0;
      next_st.divCnt = '0;
      next_st.strtCnt = '0;
    end
    else if (st.up)
    begin
      if (mid)
      begin
        next_st.up = 1'b0;
        next_st.count = (st.count == '0) ? '0 : st.count - 1'b1;
      end
      else
      begin
        next_st.count = st.count + 1'b1;
      end
    end
    else if (start)
    begin
      // one rollover per cycle, so push-pull toggles once
      next_st.up = 1'b1;
      next_st.count = st.count + 1'b1;
      next_st.ppSel = !st.ppSel;
      next_st.periodAct = st.periodBuf;
      if (!(&st.strtCnt))
      begin
        next_st.strtCnt = st.strtCnt + 1'b1;
      end
    end
    else
    begin
      next_st.count = st.count - 1'b1;
    end
    // held phase lands whole at the midpoint
    if (mid && st.phasePend)
    begin
      next_st.phaseAct = st.phaseBuf;
      next_st.phasePend = 1'b0;
    end
    // trigger divider and postscaler start
    next_st.trig = 1'b0;
    if (match && allowed)
    begin
      if (fire)
      begin
        next_st.trig = 1'b1;
        next_st.divCnt = st.trigger_output_divider;
      end
      else
      begin
        next_st.divCnt = st.divCnt - 1'b1;
      end
    end
    // register writes
    if (doWrite)
    begin
      unique case (st.awAddr[7:0] & 8'hfc)
        CTRL_OFS:
        begin
          next_st.enable = wrVal[CTRL_EN_BIT];
          next_st.swap = wrVal[CTRL_SWAP_BIT];
          next_st.immPhase = wrVal[CTRL_IMM_PHASE_BIT];
          next_st.immPeriod = wrVal[CTRL_IMM_PERIOD_BIT];
          next_st.mode = out_mode_type'(wrVal[CTRL_MODE_LSB+:2]);
        end
        PERIOD_OFS:
        begin
          next_st.periodBuf = wrVal[CW-1:0];
          if (st.immPeriod || !st.enable)
          begin
            next_st.periodAct = wrVal[CW-1:0];
          end
        end
        PHASE_OFS:
        begin
          next_st.phaseBuf = wrVal[CW-1:0];
          if (st.immPhase || !st.enable)
          begin
            next_st.phaseAct = wrVal[CW-1:0];
            next_st.phasePend = 1'b0;
          end
          else
          begin
            next_st.phasePend = 1'b1;
          end
        end
        DEAD_OFS: next_st.dead = wrVal[7:0];
        TRIG_OFS: next_st.trigCmp = wrVal[CW-1:0];
        TRGCON_OFS:
        begin
          next_st.trigger_output_divider = wrVal[TRG_DIV_LSB+:4];
          next_st.postscaler_start_select = wrVal[TRG_STRT_LSB+:6];
        end
        INTMASK_OFS: next_st.intMask = wrVal[1:0];
        default: ;
      endcase
    end
    // sticky events, set wins over write-one-to-clear
    if (doWrite && (st.awAddr[7:0] & 8'hfc) == INTST_OFS)
    begin
      next_st.intSt = st.intSt & ~wrVal[1:0];
    end
    next_st.intSt[INT_TRIG_BIT] = next_st.intSt[INT_TRIG_BIT] | fire;
    next_st.intSt[INT_CYCLE_BIT] = next_st.intSt[INT_CYCLE_BIT] | start;
    next_st.irq = |(next_st.intSt & next_st.intMask);
    // output requests by mode, swap routed ahead of dead time
    onH = 1'b0;
    onL = 1'b0;
    next_st.enforce = 1'b1;
    unique case (st.mode)
      MODE_COMPL:
      begin
        onH = on;
        onL = st.enable && !on;
      end
      MODE_REDUND:
      begin
        onH = on;
        onL = on;
        next_st.enforce = 1'b0;
      end
      MODE_PUSHPULL:
      begin
        onH = on && !st.ppSel;
        onL = on && st.ppSel;
      end
      MODE_OFF: ;
    endcase
    next_st.reqH = st.swap ? onL : onH;
    next_st.reqL = st.swap ? onH : onL;
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.awRdy <= 1'b1;
      st.wRdy <= 1'b1;
      st.arRdy <= 1'b1;
      st.up <= 1'b1;
      st.enforce <= 1'b1;
      st.periodBuf <= CW'(PERIOD_RST);
      st.periodAct <= CW'(PERIOD_RST);
      st.phaseBuf <= CW'(PHASE_RST);
      st.phaseAct <= CW'(PHASE_RST);
      st.trigCmp <= CW'(TRIG_RST);
      st.dead <= DEAD_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // dead time stage drives the pins
  dead_time_gen #(
    .DW(8)
  ) u_dead (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .reqHigh(st.reqH),
    .reqLow(st.reqL),
    .enforce(st.enforce),
    .deadCount(st.dead),
    .pinHigh(highSideOutput),
    .pinLow(lowSideOutput)
  );

  assign awready = st.awRdy;
  assign wready = st.wRdy;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arRdy;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign primaryTrigger = st.trig;
  assign irq = st.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  chk_swap_route: assert property (
    (st.enable && st.mode == MODE_COMPL) |=> st.reqL == ($past(st.swap) ? $past(on) : !$past(on)))
    else $error("swap routing wrong");
  chk_phase_held: assert property (
    (phaseWr && st.enable && !st.immPhase && !mid) |=> st.phaseAct == $past(st.phaseAct) && st.phasePend)
    else $error("deferred phase applied early");
  chk_phase_at_mid: assert property (
    (mid && st.phasePend && !phaseWr) |=> st.phaseAct == $past(st.phaseBuf) && !st.phasePend)
    else $error("held phase not applied at midpoint");
  chk_phase_now: assert property (
    (phaseWr && st.immPhase) |=> st.phaseAct == $past(wrVal[CW-1:0]))
    else $error("immediate phase not applied");
  chk_pp_alternate: assert property (
    (st.mode == MODE_PUSHPULL && start) |=> st.ppSel != $past(st.ppSel) ##1 !start)
    else $error("push-pull select did not alternate once");
  chk_period_now: assert property (
    (periodWr && st.immPeriod) |=> st.periodAct == $past(wrVal[CW-1:0]))
    else $error("immediate period not applied");
  chk_trig_fire: assert property (
    (match && st.postscaler_start_select == '0 && st.divCnt == '0) |=> st.trig ##1 !st.trig)
    else $error("trigger missed on compare");
  chk_trig_divide: assert property (
    (match && allowed && st.divCnt != '0) |=> !st.trig && st.divCnt == $past(st.divCnt) - 1'b1)
    else $error("divider let a trigger through");
  chk_strt_hold: assert property (
    (st.strtCnt < st.postscaler_start_select) |=> !st.trig)
    else $error("trigger before start count");
  chk_phase_whole: assert property (
    $changed(st.phaseAct) |-> $past(phaseWr || (mid && st.phasePend)))
    else $error("phase changed without whole update");

  cov_pp_cycle: cover property (st.mode == MODE_PUSHPULL && start ##[1:300] start);
  cov_trig_first: cover property ($rose(st.enable) ##[1:50] st.trig);
  cov_phase_mid: cover property (phaseWr && !st.immPhase ##[1:300] mid);
  cov_swap_live: cover property (st.enable && $fell(st.swap));
endmodule

//--- pwm_load_model.sv
// power stage model that watches the two gate drive pins
`timescale 1ns/1ns
module pwm_load_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // gate drive pins and the dead gap in force
  input wire logic highSideOutput,
  input wire logic lowSideOutput,
  input wire logic [7:0] deadCycles,
  // fault and activity counts
  output int deadFaults,
  output int repeatFaults,
  output int highRises,
  output int lowRises
);
  logic prevHigh, prevLow, riseHigh, riseLow;
  logic [1:0] lastSide;
  int offRun;
  // rising edges of each pin
  assign riseHigh = highSideOutput && !prevHigh;
  assign riseLow = lowSideOutput && !prevLow;
  // shoot-through, short gaps and doubled push-pull pulses are counted
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevHigh <= 1'b0;
      prevLow <= 1'b0;
      lastSide <= 2'h0;
      offRun <= 0;
      deadFaults <= 0;
      repeatFaults <= 0;
      highRises <= 0;
      lowRises <= 0;
    end
    else
    begin
      prevHigh <= highSideOutput;
      prevLow <= lowSideOutput;
      offRun <= (highSideOutput || lowSideOutput) ? 0 : offRun + 1;
      if ((highSideOutput && lowSideOutput) || ((riseHigh || riseLow) && offRun < int'(deadCycles)))
        deadFaults <= deadFaults + 1;
      if (riseHigh)
        highRises <= highRises + 1;
      if (riseLow)
        lowRises <= lowRises + 1;
      if (riseHigh || riseLow)
        lastSide <= riseHigh ? 2'h1 : 2'h2;
      if ((riseHigh && lastSide == 2'h1) || (riseLow && lastSide == 2'h2))
        repeatFaults <= repeatFaults + 1;
    end
  end
endmodule

//--- pwm_update_and_trigger_logic_tb.sv
// self-checking bench for the pwm channel
`timescale 1ns/1ns
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin nMismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pwm_update_and_trigger_logic_tb;
  import pwm_pkg::*;
  logic ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, highSideOutput, lowSideOutput, primaryTrigger, irq;
  logic [7:0] awaddr, araddr, deadSet;
  logic [31:0] wdata, rdata, rdVal;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bResp, rResp;
  int nMismatch, numChecks, hiCnt, loCnt, trgCnt, firstTrg;
  int deadFaults, repeatFaults, highRises, lowRises;
  pwm_update_and_trigger_logic u_pwm_update_and_trigger_logic (.ref_clk(ref_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .highSideOutput(highSideOutput),
    .lowSideOutput(lowSideOutput), .primaryTrigger(primaryTrigger), .irq(irq));
  pwm_load_model u_pwm_load_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput), .deadCycles(deadSet),
    .deadFaults(deadFaults), .repeatFaults(repeatFaults), .highRises(highRises),
    .lowRises(lowRises));
  // 100 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    @(posedge ref_clk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge ref_clk);
      if (awready)
        aw = 1'b0;
      if (wready)
        w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    while (!bvalid) @(posedge ref_clk);
    bResp = bresp;
    bready <= 1'b0;
  endtask
  // bus read into rdVal and rResp
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    rdVal = rdata;
    rResp = rresp;
    rready <= 1'b0;
  endtask
  // count pin and trigger activity over n cycles
  task automatic watch(input int n);
    hiCnt = 0;
    loCnt = 0;
    trgCnt = 0;
    firstTrg = 99;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      hiCnt += int'(highSideOutput);
      loCnt += int'(lowSideOutput);
      if (primaryTrigger === 1'b1)
      begin
        if (trgCnt == 0)
          firstTrg = i;
        trgCnt++;
      end
    end
  endtask
  // reprogram while stopped, then start with the given control word
  task automatic setup(input logic [31:0] ctrl, input logic [15:0] per, input logic [15:0] ph,
                       input logic [7:0] dead);
    wr(CTRL_OFS, 32'h0, 4'hf);
    wr(PERIOD_OFS, {16'h0, per}, 4'hf);
    wr(PHASE_OFS, {16'h0, ph}, 4'hf);
    wr(DEAD_OFS, {24'h0, dead}, 4'hf);
    deadSet <= dead;
    wr(CTRL_OFS, ctrl, 4'hf);
  endtask
  // clear the cycle start flag and poll until the next cycle begins
  task automatic waitCycle();
    int n;
    wr(INTST_OFS, 32'h1 << INT_CYCLE_BIT, 4'hf);
    n = 0;
    rdVal = '0;
    while (!rdVal[INT_CYCLE_BIT] && n < 40)
    begin
      rd(INTST_OFS);
      n++;
    end
    `CHK(rdVal[INT_CYCLE_BIT], 1'b1)
  endtask
  task automatic testRegs();
    logic [7:0] adr [8] = '{CTRL_OFS, PERIOD_OFS, PHASE_OFS, DEAD_OFS, TRIG_OFS, TRGCON_OFS,
                            INTST_OFS, INTMASK_OFS};
    logic [31:0] val [8] = '{32'h0, {16'h0, PERIOD_RST}, {16'h0, PHASE_RST}, {24'h0, DEAD_RST},
                             {16'h0, TRIG_RST}, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
    begin
      rd(adr[i]);
      `CHK(rdVal, val[i])
    end
    rd(8'h40);
    `CHK({rResp, rdVal}, {RESP_SLVERR, 32'h0})
    wr(8'h40, 32'h1, 4'hf);
    `CHK(bResp, RESP_SLVERR)
    wr(PERIOD_OFS, 32'h1234, 4'hf);
    wr(PERIOD_OFS, 32'h5600, 4'h2);
    rd(PERIOD_OFS);
    `CHK({rResp, rdVal}, {RESP_OKAY, 32'h5634})
    $display("done registers");
  endtask
  task automatic testSwap();
    int d0;
    d0 = deadFaults;
    setup(32'h1, 16'd20, 16'd4, 8'd2);
    watch(40);
    `CHK(hiCnt < loCnt, 1'b1)
    wr(CTRL_OFS, 32'h3, 4'hf);
    watch(40);
    `CHK(hiCnt > loCnt, 1'b1)
    wr(CTRL_OFS, 32'h1, 4'hf);
    watch(40);
    `CHK(hiCnt < loCnt, 1'b1)
    for (int i = 0; i < 8; i++)
    begin
      wr(CTRL_OFS, {30'h0, i[0], 1'b1}, 4'hf);
      repeat (i * 3) @(posedge ref_clk);
    end
    watch(40);
    `CHK(deadFaults == d0, 1'b1)
    $display("done swap");
  endtask
  task automatic testPhase();
    for (int immed = 0; immed < 2; immed++)
    begin
      // enable, with immediate update on in the second pass
      setup(immed ? 32'h5 : 32'h1, 16'd20, 16'd0, 8'd2);
      waitCycle();
      wr(PHASE_OFS, 32'd10, 4'hf);
      watch(40);
      if (immed == 0)
        `CHK(hiCnt < 12, 1'b1)
      else
        `CHK(hiCnt > 12, 1'b1)
    end
    $display("done phase");
  endtask
  task automatic testPushPull();
    int a, b, c, d;
    d = deadFaults;
    setup(32'h809, 16'd20, 16'd2, 8'd1);
    waitCycle();
    wr(PERIOD_OFS, 32'd16, 4'hf);
    repeat (6)
    begin
      rd(STAT_OFS);
      `CHK(rdVal[15:0] <= 16'd16, 1'b1)
    end
    a = repeatFaults;
    b = highRises;
    c = lowRises;
    // writes land all over the cycle, rollover included
    for (int i = 0; i < 12; i++)
      wr(PERIOD_OFS, 32'd10 + 32'(i % 2), 4'hf);
    watch(80);
    `CHK(repeatFaults == a, 1'b1)
    `CHK(highRises > b && lowRises > c, 1'b1)
    `CHK(deadFaults == d, 1'b1)
    $display("done push-pull");
  endtask
  task automatic testTrigger();
    logic [15:0] cfg [4] = '{16'h0000, 16'h1000, 16'h3000, 16'h0002};
    int want [4] = '{10, 5, 3, 8};
    wr(TRIG_OFS, 32'd3, 4'hf);
    for (int i = 0; i < 4; i++)
    begin
      wr(TRGCON_OFS, {16'h0, cfg[i]}, 4'hf);
      setup(32'h1, 16'd10, 16'd0, 8'd1);
      watch(190);
      `CHK(trgCnt == want[i], 1'b1)
      if (cfg[i][5:0] == 6'h0)
        `CHK(firstTrg < 8, 1'b1)
    end
    $display("done trigger");
  endtask
  task automatic testIrq();
    int n;
    wr(CTRL_OFS, 32'h0, 4'hf);
    wr(TRGCON_OFS, 32'h0, 4'hf);
    wr(INTST_OFS, 32'h3, 4'hf);
    wr(TRIG_OFS, 32'd8, 4'hf);
    wr(INTMASK_OFS, 32'h1, 4'hf);
    wr(CTRL_OFS, 32'h1, 4'hf);
    n = 0;
    while (irq !== 1'b1 && n < 60)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(irq, 1'b1)
    wr(CTRL_OFS, 32'h0, 4'hf);
    wr(INTMASK_OFS, 32'h0, 4'hf);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(INTMASK_OFS, 32'h1, 4'hf);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(INTST_OFS, 32'h1, 4'hf);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    rd(INTST_OFS);
    `CHK(rdVal[INT_TRIG_BIT], 1'b0)
    $display("done interrupt");
  endtask
  // verdict and end of run
  task automatic testDone();
    $display("checks=%0d mismatches=%0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    $display("watchdog expired");
    nMismatch++;
    testDone();
  end
  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    deadSet = DEAD_RST;
    nMismatch = 0;
    numChecks = 0;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    testRegs();
    testSwap();
    testPhase();
    testPushPull();
    testTrigger();
    testIrq();
    testDone();
  end
endmodule
